//--- inc/serdes_channel_pkg.sv
// Purpose : Shared constants and types of the serdes channel control block.
// Assumes : A 20 MHz reference clock; one serial bit per reference cycle.
// Notes   : Every number of the channel is named here once.
`default_nettype none

package serdes_channel_pkg;

	// ==========================================================
	// Framing
	localparam int          WORD_BITS  = 18;
	localparam int          FRAME_BITS = WORD_BITS + 2;
	localparam logic        START_BIT  = 1'h1;
	localparam logic        STOP_BIT   = 1'h0;
	localparam logic [17:0] SYNC_WORD  = 18'h3fe00;
	localparam logic [17:0] IDLE_WORD  = 18'h00000;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS     = 50;
	localparam int POR_MAX_TIME_NS   = 1000000;
	// Strictly under the limit, so one cycle short of it.
	localparam int POR_CYCLES        = POR_MAX_TIME_NS / CLK_PERIOD_NS - 1;
	localparam int SYNC_MIN_CYCLES   = 7;
	localparam int SYNC_BURST_WORDS  = 1026;
	localparam int RX_CLK_HIGH_START = FRAME_BITS / 2;

	// ==========================================================
	// Buffering
	localparam int TX_FIFO_DEPTH = 8;

	// ==========================================================
	// Channel power state
	typedef enum logic [1:0] {
		ST_DOWN,
		ST_POR,
		ST_RUN
	} power_state_type;

endpackage : serdes_channel_pkg

`default_nettype wire

//--- rtl/word_fifo.sv
// Purpose : Synchronous FIFO with valid/ready on both sides.
// Assumes : DEPTH is a power of two, at least two.
// Notes   : Full and empty come from pointers with one wrap bit.
`timescale 1ns/1ns
`default_nettype none

module word_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// Elaboration check
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("word_fifo: DEPTH must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic [AW:0]      nxt_wr_ptr;
	logic [AW:0]      nxt_rd_ptr;
	logic             push;
	logic             pop;

	// ==========================================================
	// Flags and pointer updates
	always_comb begin
		out_valid  = (wr_ptr_ff != rd_ptr_ff);
		in_ready   = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) ||
		             (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
		push       = in_valid && in_ready;
		pop        = out_valid && out_ready;
		nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
		out_data   = mem_ff[rd_ptr_ff[AW-1:0]];
	end

	// Storage holds no reset; only the pointers define content.
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
		end
	end

endmodule : word_fifo

`default_nettype wire

//--- rtl/serdes_channel_control.sv
// Purpose : Per-channel control, framing, serializer and simple receiver.
// Assumes : One serial bit per ref_clk cycle; a word every 20 cycles.
// Notes   : Three-state pins appear as value plus output enable.
`timescale 1ns/1ns
`default_nettype none

module serdes_channel_control
	import serdes_channel_pkg::*;
#(
	parameter int POR_LEN = POR_CYCLES
) (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	// Channel control pins
	input  wire logic                 channel_power_on,
	input  wire logic                 loopback_select,
	input  wire logic                 fast_sync_request,
	// Parallel transmit side
	input  wire logic [WORD_BITS-1:0] tx_parallel_word,
	input  wire logic                 tx_word_valid,
	output logic                      tx_word_ready,
	// Serial transmit pins
	output logic                      serial_out_pos,
	output logic                      serial_out_neg,
	output logic                      serial_out_oe,
	// Serial receive pins
	input  wire logic                 serial_in_pos,
	input  wire logic                 serial_in_neg,
	// Parallel receive side and power-on reset status
	output logic      [WORD_BITS-1:0] recv_parallel_bus,
	output logic                      recv_bus_oe,
	output logic                      recv_word_clock,
	output logic                      por_active
);
	localparam int PW = $clog2(POR_LEN + 1);

	// ==========================================================
	// Elaboration check
	generate
		if (POR_LEN < 1) begin : g_bad_por
			$error("serdes_channel_control: POR_LEN must be positive");
		end
	endgenerate

	// ==========================================================
	// Declarations
	power_state_type           state_ff,  nxt_state;
	logic [PW-1:0]             por_cnt_ff, nxt_por_cnt;
	logic [2:0]                sync_hi_ff, nxt_sync_hi;
	logic [10:0]               sync_left_ff, nxt_sync_left;
	logic [4:0]                tx_bit_ff, nxt_tx_bit;
	logic [FRAME_BITS-1:0]     tx_sh_ff,  nxt_tx_sh;
	logic [4:0]                rx_bit_ff, nxt_rx_bit;
	logic [FRAME_BITS-1:0]     rx_sh_ff,  nxt_rx_sh;
	logic [WORD_BITS-1:0]      rx_word_ff, nxt_rx_word;
	logic                      rx_clk_ff, nxt_rx_clk;
	logic                      oe_out_ff, nxt_oe_out;
	logic                      oe_rx_ff,  nxt_oe_rx;
	logic                      run;
	logic                      word_tick;
	logic                      sync_send;
	logic                      fifo_valid;
	logic [WORD_BITS-1:0]      fifo_word;
	logic [WORD_BITS-1:0]      tx_word;
	logic                      rx_bit;
	logic [FRAME_BITS-1:0]     rx_frame;
	logic                      fifo_in_ready;

	// ==========================================================
	// Transmit word buffer
	// Words queue here; the serializer drains one per frame, so a source
	// that pushes faster than the word rate sees tx_word_ready fall.
	word_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (TX_FIFO_DEPTH)
	) u_tx_fifo (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_valid  (tx_word_valid && run),
		.in_ready  (fifo_in_ready),
		.in_data   (tx_parallel_word),
		.out_valid (fifo_valid),
		.out_ready (word_tick && !sync_send),
		.out_data  (fifo_word)
	);

	// Handshake outputs may be combinational.
	always_comb begin
		tx_word_ready = fifo_in_ready && run;
	end

	// ==========================================================
	// Power state, power-on reset and sync request qualification
	always_comb begin
		nxt_state     = state_ff;
		nxt_por_cnt   = por_cnt_ff;
		nxt_sync_hi   = sync_hi_ff;
		nxt_sync_left = sync_left_ff;
		run           = (state_ff == ST_RUN);
		word_tick     = run && (tx_bit_ff == 5'(FRAME_BITS - 1));
		case (state_ff)
			ST_DOWN: begin
				if (channel_power_on) begin
					nxt_state   = ST_POR;
					nxt_por_cnt = '0;
				end
			end
			ST_POR: begin
				nxt_por_cnt = por_cnt_ff + 1'b1;
				if (!channel_power_on) begin
					nxt_state = ST_DOWN;
				end else if (por_cnt_ff == PW'(POR_LEN - 1)) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!channel_power_on) begin
					nxt_state = ST_DOWN;
				end
			end
			default: begin
				nxt_state = ST_DOWN;
			end
		endcase
		// A request must be seen high on 7 cycles in a row to count.
		if (!fast_sync_request || !run) begin
			nxt_sync_hi = '0;
		end else if (sync_hi_ff != 3'(SYNC_MIN_CYCLES)) begin
			nxt_sync_hi = sync_hi_ff + 1'b1;
		end
		// The burst is armed on the cycle the request qualifies.
		if (!run) begin
			nxt_sync_left = '0;
		end else if (nxt_sync_hi == 3'(SYNC_MIN_CYCLES) &&
		             sync_hi_ff != 3'(SYNC_MIN_CYCLES)) begin
			nxt_sync_left = 11'(SYNC_BURST_WORDS);
		end else if (word_tick && sync_left_ff != '0) begin
			nxt_sync_left = sync_left_ff - 1'b1;
		end
		sync_send = fast_sync_request || (sync_left_ff != '0);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff     <= ST_POR;
			por_cnt_ff   <= '0;
			sync_hi_ff   <= '0;
			sync_left_ff <= '0;
		end else begin
			state_ff     <= nxt_state;
			por_cnt_ff   <= nxt_por_cnt;
			sync_hi_ff   <= nxt_sync_hi;
			sync_left_ff <= nxt_sync_left;
		end
	end

	// ==========================================================
	// Serializer and receiver
	always_comb begin
		// An empty buffer sends a framed idle word so the far end keeps lock.
		if (sync_send) begin
			tx_word = SYNC_WORD;
		end else if (fifo_valid) begin
			tx_word = fifo_word;
		end else begin
			tx_word = IDLE_WORD;
		end
		nxt_tx_bit = '0;
		nxt_tx_sh  = '0;
		if (run) begin
			nxt_tx_bit = word_tick ? 5'h00 : tx_bit_ff + 1'b1;
			nxt_tx_sh  = {1'b0, tx_sh_ff[FRAME_BITS-1:1]};
			if (word_tick) begin
				nxt_tx_sh = {STOP_BIT, tx_word, START_BIT};
			end
		end
		nxt_oe_out = run && !loopback_select;
		nxt_oe_rx  = run;
		// Loopback takes the bit now on the wire; the pins are ignored.
		// The pins read as the positive leg; a pair stuck equal reads 0.
		rx_bit   = loopback_select ? tx_sh_ff[0] :
		           (serial_in_pos && !serial_in_neg);
		rx_frame = {rx_bit, rx_sh_ff[FRAME_BITS-1:1]};
		nxt_rx_sh   = run ? rx_frame : '0;
		nxt_rx_word = rx_word_ff;
		nxt_rx_bit  = '0;
		if (run) begin
			nxt_rx_bit = rx_bit_ff + 1'b1;
			if (rx_bit_ff == 5'(FRAME_BITS - 1)) begin
				if (rx_frame[0] == START_BIT &&
				    rx_frame[FRAME_BITS-1] == STOP_BIT) begin
					nxt_rx_word = rx_frame[FRAME_BITS-2:1];
					nxt_rx_bit  = '0;
				end else begin
					// Slip one bit and test the next boundary.
					nxt_rx_bit = rx_bit_ff;
				end
			end
		end
		// Rise mid-frame, well after the word was updated.
		nxt_rx_clk = run && (nxt_rx_bit >= 5'(RX_CLK_HIGH_START));
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_bit_ff  <= '0;
			tx_sh_ff   <= '0;
			rx_bit_ff  <= '0;
			rx_sh_ff   <= '0;
			rx_word_ff <= '0;
			rx_clk_ff  <= 1'b0;
			oe_out_ff  <= 1'b0;
			oe_rx_ff   <= 1'b0;
		end else begin
			tx_bit_ff  <= nxt_tx_bit;
			tx_sh_ff   <= nxt_tx_sh;
			rx_bit_ff  <= nxt_rx_bit;
			rx_sh_ff   <= nxt_rx_sh;
			rx_word_ff <= nxt_rx_word;
			rx_clk_ff  <= nxt_rx_clk;
			oe_out_ff  <= nxt_oe_out;
			oe_rx_ff   <= nxt_oe_rx;
		end
	end

	// ==========================================================
	// Pin drivers
	always_comb begin
		serial_out_pos    = tx_sh_ff[0];
		serial_out_neg    = ~tx_sh_ff[0];
		serial_out_oe     = oe_out_ff;
		recv_parallel_bus = rx_word_ff;
		recv_bus_oe       = oe_rx_ff;
		recv_word_clock   = rx_clk_ff;
		por_active        = (state_ff == ST_POR);
	end

endmodule : serdes_channel_control

`default_nettype wire

//--- verification/serdes_channel_sva.sv
// Purpose : Port checks of the serdes channel control block.
// Assumes : One clock domain, reset asynchronous and active low.
// Notes   : Reset length is measured by a small cycle counter.
`timescale 1ns/1ns
`default_nettype none

module serdes_channel_sva
	import serdes_channel_pkg::*;
#(
	parameter int POR_LEN = 20
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Watched ports
	input wire logic channel_power_on,
	input wire logic loopback_select,
	input wire logic por_active,
	input wire logic tx_word_ready,
	input wire logic serial_out_pos,
	input wire logic serial_out_neg,
	input wire logic serial_out_oe,
	input wire logic recv_bus_oe,
	input wire logic recv_word_clock
);
	// ==========================================================
	// Reset length counter
	logic [15:0] por_cnt_ff;
	logic [15:0] nxt_por_cnt;

	// Edges spent in reset; a repetition would be far too long here.
	always_comb begin
		nxt_por_cnt = por_active ? por_cnt_ff + 16'h0001 : 16'h0000;
	end

	// Registers the count.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			por_cnt_ff <= 16'h0000;
		else
			por_cnt_ff <= nxt_por_cnt;
	end

	// ==========================================================
	// Word clock phase length counter
	// Edges the word clock has stood at its present level, saturating.
	// A counter keeps the phase check cheap instead of a long repetition.
	logic [7:0] wclk_run_ff;
	logic [7:0] nxt_wclk_run;
	logic       wclk_prev_ff;

	// A change of level restarts the count at one.
	always_comb begin
		if (recv_word_clock != wclk_prev_ff)
			nxt_wclk_run = 8'h01;
		else if (wclk_run_ff == 8'hff)
			nxt_wclk_run = wclk_run_ff;
		else
			nxt_wclk_run = wclk_run_ff + 8'h01;
	end

	// Registers the count and the level it belongs to.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wclk_run_ff  <= 8'h00;
			wclk_prev_ff <= 1'b0;
		end else begin
			wclk_run_ff  <= nxt_wclk_run;
			wclk_prev_ff <= recv_word_clock;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// Assertions
	AST_POR_RX_QUIET: assert property (por_active |->
		!recv_bus_oe && !recv_word_clock) else $error("Rx active in reset.");
	AST_POR_LENGTH: assert property ($fell(por_active) &&
		$past(channel_power_on) |-> por_cnt_ff == POR_LEN &&
		por_cnt_ff < POR_MAX_TIME_NS / CLK_PERIOD_NS)
		else $error("Reset length wrong.");
	AST_NEG_INVERSE: assert property (serial_out_oe |->
		serial_out_neg != serial_out_pos) else $error("Pair not inverse.");
	AST_LOOP_FLOAT: assert property (loopback_select |=>
		!serial_out_oe) else $error("Serial driven in loopback.");
	AST_RUN_DRIVES: assert property ((!por_active && channel_power_on &&
		!loopback_select) [*2] |-> ##[0:2] serial_out_oe)
		else $error("Serial not driven.");
	AST_POR_SERIAL_FLOAT: assert property (por_active |->
		!serial_out_oe) else $error("Serial driven in reset.");
	AST_DOWN_FLOAT: assert property (!channel_power_on [*3] |->
		!serial_out_oe && !recv_bus_oe) else $error("Driven when down.");
	AST_WAKE_POR: assert property (!channel_power_on ##1
		channel_power_on |=> por_active) else $error("No reset on wake.");
	AST_READY_RUN: assert property (por_active |->
		!tx_word_ready) else $error("Ready during reset.");
	AST_WCLK_HIGH: assert property (disable iff (!arst_n || !channel_power_on)
		$fell(recv_word_clock) |-> wclk_run_ff >= 8'(FRAME_BITS / 2))
		else $error("Word clock high phase short.");
	AST_WCLK_LOW: assert property (disable iff (!arst_n || !channel_power_on)
		$rose(recv_word_clock) |-> wclk_run_ff >= 8'(FRAME_BITS / 2))
		else $error("Word clock low phase short.");

	COV_POR_DONE: cover property ($fell(por_active));
	COV_LOOP: cover property (loopback_select ##1 !serial_out_oe);
	COV_WAKE: cover property (!channel_power_on ##1 channel_power_on);
endmodule : serdes_channel_sva

bind serdes_channel_control serdes_channel_sva #(.POR_LEN(POR_LEN)) u_sva (
	.ref_clk, .arst_n, .channel_power_on, .loopback_select, .por_active,
	.tx_word_ready, .serial_out_pos, .serial_out_neg, .serial_out_oe,
	.recv_bus_oe, .recv_word_clock);

`default_nettype wire

//--- verification/serdes_far_end.sv
// Purpose : Remote link end: collects sent bits and echoes them back.
// Assumes : One line bit per ref_clk cycle.
// Notes   : A released line has no pull and reads as the inverse bit.
`timescale 1ns/1ns
`default_nettype none

module serdes_far_end (
	// Clock
	input  wire logic        ref_clk,
	// Line from the block
	input  wire logic        line_pos,
	input  wire logic        line_oe,
	// Line back to the block and collected bits
	output logic             echo_pos,
	output logic             echo_neg,
	output logic      [19:0] shift_ff
);
	// First bit on the line ends up in bit 0 after a frame.
	always_ff @(posedge ref_clk) begin
		if (line_oe)
			shift_ff <= {line_pos, shift_ff[19:1]};
	end

	// A floating line must never look like the data the block still holds.
	assign echo_pos = line_oe ? line_pos : !line_pos;
	assign echo_neg = !echo_pos;
endmodule : serdes_far_end

`default_nettype wire

//--- verification/serdes_channel_control_test.sv
// Purpose : Self-checking bench of the serdes channel control block.
// Assumes : Short power-on reset through POR_LEN.
// Notes   : Frames are judged on the far end's collected bits.
`timescale 1ns/1ns
`default_nettype none

module serdes_channel_control_test;
	import serdes_channel_pkg::*;
	logic ref_clk = 1'b0, arst_n = 1'b0, pwr = 1'b1, loop = 1'b0;
	logic sync = 1'b0, valid = 1'b0, ready, s_pos, s_neg, s_oe;
	logic e_pos, e_neg, bus_oe, wclk, por;
	logic [17:0] word = 18'h00000, bus;
	logic [19:0] far;
	int miscompares = 0, checks_done = 0, cycles = 0;

	serdes_channel_control #(.POR_LEN(20)) u_dut (.ref_clk(ref_clk),
		.arst_n(arst_n), .channel_power_on(pwr), .loopback_select(loop),
		.fast_sync_request(sync), .tx_parallel_word(word),
		.tx_word_valid(valid), .tx_word_ready(ready), .serial_out_pos(s_pos),
		.serial_out_neg(s_neg), .serial_out_oe(s_oe), .serial_in_pos(e_pos),
		.serial_in_neg(e_neg), .recv_parallel_bus(bus), .recv_bus_oe(bus_oe),
		.recv_word_clock(wclk), .por_active(por));
	serdes_far_end u_far (.ref_clk(ref_clk), .line_pos(s_pos),
		.line_oe(s_oe), .echo_pos(e_pos), .echo_neg(e_neg), .shift_ff(far));

	always #25 ref_clk = ~ref_clk;

	// A hang ends the run as a failure.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#5;
	endtask : step

	task automatic check(input string what, input logic [19:0] seen,
		input logic [19:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_frame(input logic [17:0] w, input int lim);
		for (int i = 0; i < lim && far !== {STOP_BIT, w, START_BIT}; i++)
			step(1);
		check("frame", far, {STOP_BIT, w, START_BIT});
	endtask : wait_frame

	task automatic push_and_receive(input logic [17:0] w);
		word = w;
		valid = 1'b1;
		for (int i = 0; i < 50 && ready !== 1'b1; i++)
			step(1);
		step(1);
		valid = 1'b0;
		for (int i = 0; i < 900 && {bus_oe, bus} !== {1'b1, w}; i++)
			step(1);
		check("rx bus", {bus_oe, bus}, {1'b1, w});
	endtask : push_and_receive

	// ==========================================================
	// Scenarios
	task automatic t_por();
		step(2);
		check("quiet", {ready, s_oe, bus_oe, wclk}, 20'h0);
		for (int i = 0; i < 30 && por; i++)
			step(1);
		check("por end", por, 20'h0);
	endtask : t_por

	// Fill until refused, then expect the words in order, then idle.
	task automatic t_fill();
		int n = 0;
		valid = 1'b1;
		for (int k = 0; k < 12; k++) begin
			word = 18'(18'h2a5c3 ^ (n * 18'h01111));
			if (ready === 1'b1)
				n++;
			step(1);
		end
		valid = 1'b0;
		check("fill", n == 8 || n == 9, 20'h1);
		for (int i = 0; i < n; i++)
			wait_frame(18'(18'h2a5c3 ^ (i * 18'h01111)), 45);
		wait_frame(IDLE_WORD, 45);
	endtask : t_fill

	// Six cycles high is too short to count; a long request sends a burst.
	task automatic t_sync();
		int n;
		sync = 1'b1;
		step(6);
		sync = 1'b0;
		// Skip the idle frame already on its way, judge the next one.
		step(20);
		wait_frame(IDLE_WORD, 60);
		sync = 1'b1;
		wait_frame(SYNC_WORD, 45);
		sync = 1'b0;
		// Count the sync frames, one frame period apart.
		n = 1;
		step(20);
		while (n < 1100 && far === {STOP_BIT, SYNC_WORD, START_BIT}) begin
			n++;
			step(20);
		end
		check("burst", 20'(n), 20'(SYNC_BURST_WORDS));
		wait_frame(IDLE_WORD, 45);
	endtask : t_sync

	task automatic t_loop();
		loop = 1'b1;
		step(2);
		check("loop float", s_oe, 20'h0);
		push_and_receive(18'h1b2c7);
		loop = 1'b0;
		step(3);
		check("loop off", s_oe, 20'h1);
		push_and_receive(18'h0d3e9);
		// The word clock rises half a frame after the bus takes the word.
		step(RX_CLK_HIGH_START - 1);
		check("wclk low", {wclk, bus}, {1'b0, 18'h0d3e9});
		step(1);
		check("wclk rise", {wclk, bus}, {1'b1, 18'h0d3e9});
	endtask : t_loop

	task automatic t_down();
		pwr = 1'b0;
		step(3);
		check("down", {s_oe, bus_oe}, 20'h0);
		pwr = 1'b1;
		step(2);
		check("wake", por, 20'h1);
		step(30);
		word = 18'h3c0f1;
		valid = 1'b1;
		check("ready", ready, 20'h1);
		step(1);
		valid = 1'b0;
		wait_frame(18'h3c0f1, 60);
	endtask : t_down

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	initial begin
		step(20);
		arst_n = 1'b1;
		t_por();
		t_fill();
		t_sync();
		t_loop();
		t_down();
		finish_test();
	end
endmodule : serdes_channel_control_test

`default_nettype wire
